// [logic/vsid_pkg.sv]
package vsid_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] VSID_OFS_CTL4 = 12'hF90;
   localparam logic [11:0] VSID_OFS_BASE4 = 12'hF94;
   localparam logic [11:0] VSID_OFS_LIMIT4 = 12'hF98;
   localparam logic [11:0] VSID_OFS_XLAT4 = 12'hF9C;
   localparam logic [11:0] VSID_OFS_CTL5 = 12'hFA4;
   localparam logic [11:0] VSID_OFS_CMD = 12'hFC0;
   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int VSID_B_EN = 31;
   localparam int VSID_B_POST = 30;
   localparam int VSID_B_PREF = 29;
   localparam int VSID_B_PRGDAT = 22;
   localparam int VSID_B_SUPER = 20;
   localparam int VSID_B_VSPACE = 16;
   localparam int VSID_B_WIDE = 7;
   localparam int VSID_B_LOCK = 6;
   localparam int VSID_B_PSPACE = 0;
   localparam int VSID_PAGE_LSB = 12;
   localparam logic [31:0] VSID_CTL_WMASK = 32'hE0F700C3;
   localparam logic [31:0] VSID_ADR_MASK = 32'hFFFFF000;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] VSID_CTL_RST = 32'h00F00000;
   localparam logic [31:0] VSID_ADR_RST = 32'h00000000;
   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [2:0] VSID_VSP_A16 = 3'h0;
   localparam logic [2:0] VSID_VSP_A24 = 3'h1;
   localparam logic [2:0] VSID_VSP_A32 = 3'h2;
   localparam logic [2:0] VSID_VSP_USR1 = 3'h6;
   localparam logic [2:0] VSID_VSP_USR2 = 3'h7;
   localparam logic [1:0] VSID_PSP_MEM = 2'h0;
   localparam logic [1:0] VSID_PSP_IO = 2'h1;
   localparam logic [1:0] VSID_PSP_CFG = 2'h2;
   typedef enum logic [1:0] {VSID_PH_IDLE, VSID_PH_DATA} vsid_phase_e;
endpackage : vsid_pkg

// [logic/vsid_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module vsid_regs
   import vsid_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // register contents
   output logic [31:0] ctl4,
   output logic [31:0] base4,
   output logic [31:0] limit4,
   output logic [31:0] xlat4,
   output logic [31:0] ctl5,
   output logic bus_master_enable,
   // status readback
   input wire logic [31:0] status
);
   // ------------------------------------------------------------
   // address phase capture
   // ------------------------------------------------------------
   vsid_phase_e ph_q, ph_d;
   logic [11:0] adr_q, adr_d;
   logic wr_q, wr_d;
   logic [31:0] ctl4_q, ctl4_d, base4_q, base4_d, limit4_q, limit4_d;
   logic [31:0] xlat4_q, xlat4_d, ctl5_q, ctl5_d, rd_q, rd_d;
   logic bme_q, bme_d;
   logic take;

   assign take = hsel && hready && htrans[1] && (hsize == 3'h2);
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0;
   assign hrdata = rd_q;

   // next state: writes land in the data phase, reads decode at address phase
   always_comb begin
      ph_d = take ? VSID_PH_DATA : VSID_PH_IDLE;
      adr_d = take ? haddr[11:0] : adr_q;
      wr_d = take && hwrite;
      ctl4_d = ctl4_q;
      base4_d = base4_q;
      limit4_d = limit4_q;
      xlat4_d = xlat4_q;
      ctl5_d = ctl5_q;
      bme_d = bme_q;
      rd_d = 32'h00000000;
      if (ph_q == VSID_PH_DATA && wr_q) begin
         unique case (adr_q)
            VSID_OFS_CTL4: ctl4_d = hwdata & VSID_CTL_WMASK;
            VSID_OFS_BASE4: base4_d = hwdata & VSID_ADR_MASK;
            VSID_OFS_LIMIT4: limit4_d = hwdata & VSID_ADR_MASK;
            VSID_OFS_XLAT4: xlat4_d = hwdata & VSID_ADR_MASK;
            VSID_OFS_CTL5: ctl5_d = hwdata & VSID_CTL_WMASK;
            VSID_OFS_CMD: bme_d = hwdata[2];
            default: ;
         endcase
      end
      if (take && !hwrite) begin
         unique case (haddr[11:0])
            VSID_OFS_CTL4: rd_d = ctl4_q;
            VSID_OFS_BASE4: rd_d = base4_q;
            VSID_OFS_LIMIT4: rd_d = limit4_q;
            VSID_OFS_XLAT4: rd_d = xlat4_q;
            VSID_OFS_CTL5: rd_d = ctl5_q;
            VSID_OFS_CMD: rd_d = {29'h0, bme_q, 2'h0} | status;
            default: rd_d = 32'h00000000; // unmapped reads zero
         endcase
      end
   end

   // register update
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ph_q <= VSID_PH_IDLE;
         adr_q <= 12'h000;
         wr_q <= 1'b0;
         ctl4_q <= VSID_CTL_RST;
         base4_q <= VSID_ADR_RST;
         limit4_q <= VSID_ADR_RST;
         xlat4_q <= VSID_ADR_RST;
         ctl5_q <= VSID_CTL_RST;
         bme_q <= 1'b0;
         rd_q <= 32'h00000000;
      end else begin
         ph_q <= ph_d;
         adr_q <= adr_d;
         wr_q <= wr_d;
         ctl4_q <= ctl4_d;
         base4_q <= base4_d;
         limit4_q <= limit4_d;
         xlat4_q <= xlat4_d;
         ctl5_q <= ctl5_d;
         bme_q <= bme_d;
         rd_q <= rd_d;
      end
   end

   assign ctl4 = ctl4_q;
   assign base4 = base4_q;
   assign limit4 = limit4_q;
   assign xlat4 = xlat4_q;
   assign ctl5 = ctl5_q;
   assign bus_master_enable = bme_q;
endmodule : vsid_regs
`default_nettype wire

// [logic/vsid_match.sv]
`timescale 1ns/1ps
`default_nettype none
module vsid_match
   import vsid_pkg::*;
(
   // image window
   input wire logic [31:0] base,
   input wire logic [31:0] limit,
   input wire logic [31:0] xlat,
   // incoming address
   input wire logic [31:0] addr,
   // results
   output logic in_window,
   output logic [31:0] dest
);
   logic [19:0] pg;
   logic [19:0] dpg;
   // page compare only, low 12 bits never take part
   assign pg = addr[31:VSID_PAGE_LSB];
   assign in_window = (pg >= base[31:VSID_PAGE_LSB]) &&
      ((limit[31:VSID_PAGE_LSB] == 20'h00000) || (pg < limit[31:VSID_PAGE_LSB]));
   // plain wraparound add; negative offsets rely on twos complement
   assign dpg = pg + xlat[31:VSID_PAGE_LSB];
   assign dest = {dpg, addr[VSID_PAGE_LSB-1:0]};
endmodule : vsid_match
`default_nettype wire

// [logic/vsid_top.sv]
`timescale 1ns/1ps
`default_nettype none
module vsid_top
   import vsid_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // incoming vme cycle, one-cycle strobe
   input wire logic vme_strobe,
   input wire logic [31:0] vme_addr,
   input wire logic [5:0] vme_am,
   input wire logic vme_write,
   input wire logic vme_rmw,
   input wire logic vme_user_space,
   input wire logic vme_user_sel,
   // queue and pci side status
   input wire logic queue_accepted,
   // forwarded cycle
   output logic fwd_valid,
   output logic [31:0] fwd_addr,
   output logic [1:0] fwd_space,
   output logic fwd_write,
   output logic fwd_posted,
   output logic fwd_prefetch,
   output logic fwd_wide,
   output logic fwd_lock,
   output logic vme_ack_early
);
   logic [31:0] ctl4, base4, limit4, xlat4;
   logic bme, in_win, hit, am_ok, space_ok, is_mem, is_sup, is_prog;
   logic [31:0] dest;
   logic [31:0] status;
   logic [1:0] prg_f, sup_f, psp_f;
   logic [2:0] vsp_f;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   vsid_regs vsid_regs_inst (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .ctl4(ctl4),
      .base4(base4),
      .limit4(limit4),
      .xlat4(xlat4),
      .ctl5(),
      .bus_master_enable(bme),
      .status(status)
   );

   // ------------------------------------------------------------
   // address window
   // ------------------------------------------------------------
   vsid_match vsid_match_inst (
      .base(base4),
      .limit(limit4),
      .xlat(xlat4),
      .addr(vme_addr),
      .in_window(in_win),
      .dest(dest)
   );

   // field extraction
   assign prg_f = ctl4[VSID_B_PRGDAT +: 2];
   assign sup_f = ctl4[VSID_B_SUPER +: 2];
   assign vsp_f = ctl4[VSID_B_VSPACE +: 3];
   assign psp_f = ctl4[VSID_B_PSPACE +: 2];
   assign is_mem = (psp_f == VSID_PSP_MEM);

   // am code qualifiers: bit 2 supervisor, low bits 10 = program
   assign is_sup = vme_am[2];
   assign is_prog = (vme_am[1:0] == 2'h2);
   assign am_ok = (is_prog ? prg_f[1] : prg_f[0]) && (is_sup ? sup_f[1] : sup_f[0]);

   // address space from am code, user spaces by side inputs
   always_comb begin
      space_ok = 1'b0;
      if (vme_user_space) begin
         space_ok = (vsp_f == (vme_user_sel ? VSID_VSP_USR2 : VSID_VSP_USR1));
      end else begin
         unique case (vme_am[5:3])
            3'h5: space_ok = (vsp_f == VSID_VSP_A16);
            3'h7: space_ok = (vsp_f == VSID_VSP_A24);
            3'h1: space_ok = (vsp_f == VSID_VSP_A32);
            default: space_ok = 1'b0;
         endcase
      end
   end

   // claim only with image and bus master enabled
   assign hit = vme_strobe && ctl4[VSID_B_EN] && bme && in_win && am_ok && space_ok
      && (psp_f != 2'h3);
   assign status = {31'h0, hit};

   // ------------------------------------------------------------
   // forwarded cycle registers
   // ------------------------------------------------------------
   logic fv_q, fv_d, fw_q, fw_d, fp_q, fp_d, fr_q, fr_d, fwi_q, fwi_d, fl_q, fl_d;
   logic [31:0] fa_q, fa_d;
   logic [1:0] fs_q, fs_d;

   // capture on each claimed cycle
   always_comb begin
      fv_d = hit;
      fa_d = hit ? dest : fa_q;
      fs_d = hit ? psp_f : fs_q;
      fw_d = hit ? vme_write : fw_q;
      fp_d = hit ? (vme_write && ctl4[VSID_B_POST] && is_mem) : fp_q;
      fr_d = hit ? (!vme_write && ctl4[VSID_B_PREF] && is_mem) : fr_q;
      fwi_d = hit ? ctl4[VSID_B_WIDE] : fwi_q;
      fl_d = hit ? (vme_rmw && ctl4[VSID_B_LOCK]) : fl_q;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fv_q <= 1'b0;
         fa_q <= 32'h00000000;
         fs_q <= 2'h0;
         fw_q <= 1'b0;
         fp_q <= 1'b0;
         fr_q <= 1'b0;
         fwi_q <= 1'b0;
         fl_q <= 1'b0;
      end else begin
         fv_q <= fv_d;
         fa_q <= fa_d;
         fs_q <= fs_d;
         fw_q <= fw_d;
         fp_q <= fp_d;
         fr_q <= fr_d;
         fwi_q <= fwi_d;
         fl_q <= fl_d;
      end
   end

   assign fwd_valid = fv_q;
   assign fwd_addr = fa_q;
   assign fwd_space = fs_q;
   assign fwd_write = fw_q;
   assign fwd_posted = fp_q;
   assign fwd_prefetch = fr_q;
   assign fwd_wide = fwi_q;
   assign fwd_lock = fl_q;
   // coupled cycles wait for the pci side, posted ones ack on queue entry
   assign vme_ack_early = fv_q && fp_q && queue_accepted;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_bme_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid |-> $past(bme)) else $error("claim without bus master");
   a_enable_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid |-> $past(ctl4[VSID_B_EN])) else $error("claim while disabled");
   a_post_mem: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_posted |-> fwd_space == VSID_PSP_MEM) else $error("posted non memory");
   a_pref_mem: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_prefetch |-> fwd_space == VSID_PSP_MEM) else $error("prefetch non mem");
   a_xlat_sum: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit |=> fwd_addr == $past(vme_addr) + $past(xlat4)) else $error("bad translation");
   a_low_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit |-> vme_addr[31:12] >= base4[31:12]) else $error("below base");
   a_high_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit && limit4 != 32'h0 |-> vme_addr[31:12] < limit4[31:12]) else $error("above limit");
   a_lock_rmw: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_lock |-> $past(vme_rmw) && $past(ctl4[VSID_B_LOCK]))
      else $error("bad lock");
   a_wide_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit |=> fwd_wide == $past(ctl4[VSID_B_WIDE])) else $error("wide mismatch");
   a_ack_posted: assert property (@(posedge clk_sys) disable iff (!nrst)
      vme_ack_early |-> fwd_posted && fwd_write) else $error("early ack coupled");
   a_no_resv_psp: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid |-> fwd_space != 2'h3) else $error("reserved pci space");
   a_am_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit && prg_f == 2'h1 |-> !is_prog) else $error("program am passed");
   // forwarded space follows the control field of the claim cycle
   a_space_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid |-> fwd_space == $past(psp_f)) else $error("space not forwarded");
   // a claim only ever follows a presented cycle
   a_claim_strobe: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid |-> $past(vme_strobe)) else $error("claim without cycle");
   a_post_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_posted |-> $past(ctl4[VSID_B_POST])) else $error("posted unenabled");
   a_pref_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_prefetch |-> $past(ctl4[VSID_B_PREF])) else $error("prefetch unenabled");
   a_pref_read: assert property (@(posedge clk_sys) disable iff (!nrst)
      fwd_valid && fwd_prefetch |-> !fwd_write) else $error("prefetch on write");
   a_user_space: assert property (@(posedge clk_sys) disable iff (!nrst)
      hit && vme_user_space |-> vsp_f[2:1] == 2'h3) else $error("user space mismatch");
endmodule : vsid_top
`default_nettype wire

// [sim/vsid_vme_master.sv]
`timescale 1ns/1ps
`default_nettype none
module vsid_vme_master (
   // clock
   input wire logic clk_sys,
   // cycle towards the image
   output logic vme_strobe,
   output logic [31:0] vme_addr,
   output logic [5:0] vme_am,
   output logic vme_write,
   output logic vme_rmw,
   output logic vme_user_space,
   output logic vme_user_sel
);
   // ------------------------
   // vme master board model
   // ------------------------
   // quiet bus at power-up
   initial begin
      vme_strobe = 1'b0;
      vme_addr = 32'h0;
      vme_am = 6'h0;
      {vme_write, vme_rmw, vme_user_space, vme_user_sel} = 4'h0;
   end

   // one cycle; f is write, rmw, user space, user select
   task automatic issue(input logic [31:0] a, input logic [5:0] am, input logic [3:0] f);
      @(posedge clk_sys);
      vme_strobe <= 1'b1;
      vme_addr <= a;
      vme_am <= am;
      {vme_write, vme_rmw, vme_user_space, vme_user_sel} <= f;
      @(posedge clk_sys);
      // lines no longer valid: show inverted junk, not the old value
      vme_strobe <= 1'b0;
      vme_addr <= ~a;
      vme_am <= ~am;
      {vme_write, vme_rmw, vme_user_space, vme_user_sel} <= ~f;
   endtask : issue
endmodule : vsid_vme_master
`default_nettype wire

// [sim/vsid_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module vsid_top_tb
   import vsid_pkg::*;
;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic queue_accepted = 1'b0;
   logic hreadyout, hresp, vme_strobe, vme_write, vme_rmw, vme_user_space, vme_user_sel;
   logic [31:0] hrdata, vme_addr, fwd_addr;
   logic [5:0] vme_am;
   logic [1:0] fwd_space;
   logic fwd_valid, fwd_write, fwd_posted, fwd_prefetch, fwd_wide, fwd_lock, vme_ack_early;
   int fails = 0;
   int total_checks = 0;
   // window walk, qualifier and space tables
   logic [31:0] wa [5] = '{32'h0000FFFF, 32'h00010000, 32'h00010FFF, 32'h0001FFFF, 32'h00020000};
   logic wh [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [31:0] qc [4] = '{32'h80720000, 32'h80B20000, 32'h80D20000, 32'h80E20000};
   logic [5:0] qm [4] = '{6'h0E, 6'h0D, 6'h0D, 6'h09};
   logic [5:0] qh [4] = '{6'h0D, 6'h0E, 6'h09, 6'h0D};
   logic [2:0] vc [5] = '{VSID_VSP_A16, VSID_VSP_A24, VSID_VSP_A32, VSID_VSP_USR1, VSID_VSP_USR2};
   logic [5:0] va [5] = '{6'h2D, 6'h3D, 6'h0D, 6'h0D, 6'h0D};
   logic [3:0] vf [5] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h3};

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   vsid_top vsid_top_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vme_strobe(vme_strobe),
      .vme_addr(vme_addr), .vme_am(vme_am), .vme_write(vme_write), .vme_rmw(vme_rmw),
      .vme_user_space(vme_user_space), .vme_user_sel(vme_user_sel),
      .queue_accepted(queue_accepted), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
      .fwd_space(fwd_space), .fwd_write(fwd_write), .fwd_posted(fwd_posted),
      .fwd_prefetch(fwd_prefetch), .fwd_wide(fwd_wide), .fwd_lock(fwd_lock),
      .vme_ack_early(vme_ack_early));

   vsid_vme_master vsid_vme_master_inst (.clk_sys(clk_sys), .vme_strobe(vme_strobe),
      .vme_addr(vme_addr), .vme_am(vme_am), .vme_write(vme_write), .vme_rmw(vme_rmw),
      .vme_user_space(vme_user_space), .vme_user_sel(vme_user_sel));

   // ------------------------
   // compare and bus tasks
   // ------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic bchk(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask : bchk

   // single word transfer; waits on hready, no fixed latency assumed
   task automatic ahb(input logic w, input logic [11:0] o, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, o};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      r = hrdata;
   endtask : ahb

   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, o, d, r);
   endtask : wr

   task automatic rchk(input string n, input logic [11:0] o, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, o, 32'h0, r);
      chk(n, e, r);
      bchk("hresp", 1'b0, hresp);
   endtask : rchk

   // fwd_valid stands one cycle after the strobe edge
   task automatic vcyc(input logic [31:0] a, input logic [5:0] am, input logic [3:0] f,
                       input logic hit, input logic [31:0] dst);
      vsid_vme_master_inst.issue(a, am, f);
      #1;
      bchk("fwd_valid", hit, fwd_valid);
      if (hit) chk("fwd_addr", dst, fwd_addr);
   endtask : vcyc

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      rchk("ctl4", VSID_OFS_CTL4, 32'h00F00000);
      rchk("base4", VSID_OFS_BASE4, 32'h0);
      rchk("limit4", VSID_OFS_LIMIT4, 32'h0);
      rchk("xlat4", VSID_OFS_XLAT4, 32'h0);
      rchk("ctl5", VSID_OFS_CTL5, 32'h00F00000);
      rchk("unmapped", 12'hF00, 32'h0);
      rchk("cmd", VSID_OFS_CMD, 32'h0);
      wr(VSID_OFS_CTL5, 32'hFFFFFFFF);
      rchk("ctl5", VSID_OFS_CTL5, 32'hE0F700C3);
      wr(VSID_OFS_BASE4, 32'hFFFFFFFF);
      rchk("base4", VSID_OFS_BASE4, 32'hFFFFF000);
      // window 64K up to 128K, offset of minus 64K
      wr(VSID_OFS_BASE4, 32'h00010000);
      wr(VSID_OFS_LIMIT4, 32'h00020000);
      wr(VSID_OFS_XLAT4, 32'hFFFF0000);
      wr(VSID_OFS_CTL4, 32'h80F20000);
      vcyc(32'h00010000, 6'h0D, 4'h0, 1'b0, 32'h0);
      wr(VSID_OFS_CMD, 32'h4);
      rchk("cmd", VSID_OFS_CMD, 32'h4);
      for (int i = 0; i < 5; i++) vcyc(wa[i], 6'h0D, 4'h0, wh[i], wa[i] + 32'hFFFF0000);
      wr(VSID_OFS_LIMIT4, 32'h0);
      vcyc(32'hFFFFF123, 6'h0D, 4'h0, 1'b1, 32'hFFFEF123);
      for (int i = 0; i < 4; i++) begin
         wr(VSID_OFS_CTL4, qc[i]);
         vcyc(32'h00010000, qm[i], 4'h0, 1'b0, 32'h0);
         vcyc(32'h00010000, qh[i], 4'h0, 1'b1, 32'h0);
      end
      wr(VSID_OFS_BASE4, 32'h0);
      wr(VSID_OFS_XLAT4, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(VSID_OFS_CTL4, 32'h80F00000 | {13'h0, vc[i], 16'h0});
         vcyc(32'h100, va[i], vf[i], 1'b1, 32'h100);
         vcyc(32'h100, va[(i + 1) % 5], vf[(i + 1) % 5], 1'b0, 32'h0);
      end
      @(posedge clk_sys);
      queue_accepted <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(VSID_OFS_CTL4, 32'hE0F200C0 | 32'(k));
         vcyc(32'h100, 6'h0D, 4'hC, k < 3, 32'h100);
         if (k < 3) begin
            chk("space", 32'(k), {30'h0, fwd_space});
            bchk("posted", k == 0, fwd_posted);
            bchk("ack", k == 0, vme_ack_early);
            bchk("wide", 1'b1, fwd_wide);
            bchk("lock", 1'b1, fwd_lock);
            bchk("write", 1'b1, fwd_write);
            vcyc(32'h100, 6'h0D, 4'h0, 1'b1, 32'h100);
            bchk("prefetch", k == 0, fwd_prefetch);
            bchk("write", 1'b0, fwd_write);
            bchk("lock", 1'b0, fwd_lock);
         end
      end
      wr(VSID_OFS_CTL4, 32'h80F20000);
      vcyc(32'h100, 6'h0D, 4'hC, 1'b1, 32'h100);
      bchk("wide", 1'b0, fwd_wide);
      bchk("lock", 1'b0, fwd_lock);
      bchk("posted", 1'b0, fwd_posted);
      wr(VSID_OFS_CTL4, 32'h00F20000);
      vcyc(32'h100, 6'h0D, 4'h0, 1'b0, 32'h0);
      stop_test();
   end

   // watchdog: the run needs about 190 cycles
   initial begin
      #(50 * 20000);
      fails++;
      stop_test();
   end
endmodule : vsid_top_tb
`default_nettype wire
